/* hw/epi_top.sv */
// external pin interrupt: pin synchroniser, edge/level detection, event flag and AXI4-Lite register
`timescale 1ns/1ns

module epi_top (
	// clock and synchronous active-low reset
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	// pin side: external request pin, pull device control, interrupt request
	input  wire logic                 irq_pin,
	output epi_pkg::epi_pull_t        pull_ctrl,
	output logic                      cpu_irq,
	// register bus, write address, write data and write response
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// register bus, read address and read data
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	import epi_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// control word and event flag
	epi_ctrl_t   ctrl_q;
	epi_ctrl_t   ctrl_d;
	logic        flag_q;
	logic        flag_d;
	// pin synchroniser and edge history
	logic        sync1_q;
	logic        sync1_d;
	logic        sync2_q;
	logic        sync2_d;
	logic        prev_q;
	logic        prev_d;
	// write channel holding slots and response
	logic        aw_have_q;
	logic        aw_have_d;
	logic [11:0] aw_addr_q;
	logic [11:0] aw_addr_d;
	logic        w_have_q;
	logic        w_have_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic        w_strb0_q;
	logic        w_strb0_d;
	logic        bvalid_q;
	logic        bvalid_d;
	logic [1:0]  bresp_q;
	logic [1:0]  bresp_d;
	// read channel response
	logic        rvalid_q;
	logic        rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0]  rresp_q;
	logic [1:0]  rresp_d;
	// decode and detection terms
	logic        pin_active;
	logic        pin_event;
	logic        wr_fire;
	logic        wr_hit;
	logic        ack_wr;
	logic [7:0]  reg_view;

	// ------------------------------------------------------------
	// pin path
	// ------------------------------------------------------------
	// two-flop synchroniser then a history flop for edges
	// the pin is asynchronous, so only sync2 and the history flop fed from it feed any decision; sync1 may be metastable
	// flops reset high to match the idle level of the reset falling polarity; the pull device is off until the pin is enabled
	always_comb begin
		sync1_d = irq_pin;
		sync2_d = sync1_q;
		prev_d  = sync2_q;
	end

	// register the synchroniser chain
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q  <= 1'b1;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q  <= prev_d;
		end
	end

	// asserted level and qualifying event
	// edge mode needs a change into the asserted level, level mode fires every cycle at it
	// a cleared pin enable masks both, so a disabled pin can never set the flag
	always_comb begin
		pin_active = ctrl_q.edge_polarity_select ? sync2_q : ~sync2_q;
		pin_event  = 1'b0;
		if (ctrl_q.pin_function_enable) begin
			if (ctrl_q.level_detect_mode) begin
				pin_event = pin_active;
			end else begin
				pin_event = pin_active & (sync2_q != prev_q);
			end
		end
	end

	// pull device follows enable, disable bit and polarity
	// the pull device is only switched on while the pin function is enabled
	// polarity picks the direction so the pull holds the pin at its inactive level
	always_comb begin
		pull_ctrl.pull_enable = ctrl_q.pin_function_enable & ~ctrl_q.pull_device_disable;
		pull_ctrl.pull_down   = ctrl_q.edge_polarity_select;
	end

	// request is a plain gate of two flops, so it drops as soon as the flag clears
	assign cpu_irq = ctrl_q.pin_interrupt_enable & flag_q;

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	// a slot refuses a second item until the held write has been carried out
	assign s_axi_awready = ~aw_have_q;
	assign s_axi_wready  = ~w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	// both address and data held, response slot free
	// a write only executes once the previous response has been taken
	always_comb begin
		wr_fire = aw_have_q & w_have_q & ~bvalid_q;
		wr_hit  = (aw_addr_q & EPI_ADDR_MASK) == EPI_STATUS_CONTROL_OFS;
		ack_wr  = wr_fire & wr_hit & w_strb0_q & w_data_q[EPI_BIT_ACK];
	end

	// capture address and data in any order, answer after both
	// address and data may arrive on the same edge or on different ones
	// an unmapped address still completes, with an error response and no effect
	// a strobe without byte lane 0 writes nothing and acknowledges nothing
	always_comb begin
		aw_have_d = aw_have_q;
		aw_addr_d = aw_addr_q;
		w_have_d  = w_have_q;
		w_data_d  = w_data_q;
		w_strb0_d = w_strb0_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		// take an item only into an empty slot
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d  = 1'b1;
			w_data_d  = s_axi_wdata;
			w_strb0_d = s_axi_wstrb[0];
		end
		// executing frees both slots and raises the response
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_hit ? EPI_RESP_OKAY : EPI_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// register the write channel state
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 12'h000;
			w_have_q  <= 1'b0;
			w_data_q  <= 32'h00000000;
			w_strb0_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= EPI_RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			aw_addr_q <= aw_addr_d;
			w_have_q  <= w_have_d;
			w_data_q  <= w_data_d;
			w_strb0_q <= w_strb0_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ------------------------------------------------------------
	// control register and event flag
	// ------------------------------------------------------------
	// writable bits only, byte lane 0; flag set beats acknowledge
	// event set is applied after the acknowledge, so a coincident event is never lost
	// in level mode this also keeps the flag up while the pin sits at its asserted level
	// bit 7, the flag and the acknowledge have no storage in the control word
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_fire && wr_hit && w_strb0_q) begin
			ctrl_d.pull_device_disable  = w_data_q[EPI_BIT_PULL_DISABLE];
			ctrl_d.edge_polarity_select = w_data_q[EPI_BIT_POLARITY];
			ctrl_d.pin_function_enable  = w_data_q[EPI_BIT_PIN_ENABLE];
			ctrl_d.pin_interrupt_enable = w_data_q[EPI_BIT_IRQ_ENABLE];
			ctrl_d.level_detect_mode    = w_data_q[EPI_BIT_LEVEL_MODE];
		end
		// event flag: cleared by acknowledge, set by a qualifying event
		flag_d = flag_q;
		if (ack_wr) begin
			flag_d = 1'b0;
		end
		if (pin_event) begin
			flag_d = 1'b1;
		end
	end

	// register the control word and the flag
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl_q <= epi_ctrl_t'(5'h00);
			flag_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			flag_q <= flag_d;
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	// register image: bit 7 and acknowledge read as zero
	// the acknowledge bit has no storage, so it always reads back as zero
	always_comb begin
		reg_view                       = EPI_CTRL_RESET;
		reg_view[EPI_BIT_PULL_DISABLE] = ctrl_q.pull_device_disable;
		reg_view[EPI_BIT_POLARITY]     = ctrl_q.edge_polarity_select;
		reg_view[EPI_BIT_PIN_ENABLE]   = ctrl_q.pin_function_enable;
		reg_view[EPI_BIT_FLAG]         = flag_q;
		reg_view[EPI_BIT_IRQ_ENABLE]   = ctrl_q.pin_interrupt_enable;
		reg_view[EPI_BIT_LEVEL_MODE]   = ctrl_q.level_detect_mode;
	end

	// read response outputs straight from flops
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// one read at a time, answer the cycle after the address is taken
	// data is captured on the address edge and stands unchanged until rready
	// arready stays low while a response waits, so reads never overlap
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			// only the one word is mapped; anything else answers with an error
			if ((s_axi_araddr & EPI_ADDR_MASK) == EPI_STATUS_CONTROL_OFS) begin
				rdata_d = {24'h000000, reg_view};
				rresp_d = EPI_RESP_OKAY;
			end else begin
				rdata_d = 32'h00000000;
				rresp_d = EPI_RESP_SLVERR;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// register the read channel state
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= EPI_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q  <= rdata_d;
			rresp_q  <= rresp_d;
		end
	end
endmodule

/* hw/epi_pkg.sv */
// package for the external pin interrupt block: register map, fields, reset values
package epi_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [11:0] EPI_STATUS_CONTROL_OFS = 12'h000;
	localparam logic [11:0] EPI_ADDR_MASK          = 12'hFFC;
	localparam logic [7:0]  EPI_CTRL_RESET         = 8'h00;
	localparam logic [7:0]  EPI_CTRL_WR_MASK       = 8'h73;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int EPI_BIT_PULL_DISABLE = 6;
	localparam int EPI_BIT_POLARITY     = 5;
	localparam int EPI_BIT_PIN_ENABLE   = 4;
	localparam int EPI_BIT_FLAG         = 3;
	localparam int EPI_BIT_ACK          = 2;
	localparam int EPI_BIT_IRQ_ENABLE   = 1;
	localparam int EPI_BIT_LEVEL_MODE   = 0;

	// ------------------------------------------------------------
	// bus responses
	// ------------------------------------------------------------
	localparam logic [1:0] EPI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] EPI_RESP_SLVERR = 2'h2;

	// control fields
	typedef struct packed {
		logic pull_device_disable;
		logic edge_polarity_select;
		logic pin_function_enable;
		logic pin_interrupt_enable;
		logic level_detect_mode;
	} epi_ctrl_t;

	// pull device controls
	typedef struct packed {
		logic pull_enable;
		logic pull_down;
	} epi_pull_t;
endpackage

/* dv/epi_properties.sv */
// checker for the external pin interrupt block ports
`timescale 1ns/1ns
module epi_properties (
	input wire logic          mclk,
	input wire logic          resetn,
	input epi_pkg::epi_pull_t pull_ctrl,
	input wire logic          cpu_irq,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic [1:0]    s_axi_rresp
);
	import epi_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// reset clears cpu_irq, pull_ctrl and bvalid whatever came before
	property p_rst;
		disable iff (1'h0) !resetn |=> !cpu_irq && pull_ctrl == 2'h0 && !s_axi_bvalid;
	endproperty
	a_rst: assert property (p_rst) else $error("reset clear");
	// bus answers hold and come in time
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_ar2r;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar2r: assert property (p_ar2r) else $error("read late");
	property p_w2b;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid;
	endproperty
	a_w2b: assert property (p_w2b) else $error("write late");
	// read data shape and pin outputs against read-back bits
	property p_rhi;
		s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0;
	endproperty
	a_rhi: assert property (p_rhi) else $error("upper bits set");
	property p_ack0;
		s_axi_rvalid |-> !s_axi_rdata[2];
	endproperty
	a_ack0: assert property (p_ack0) else $error("ack bit read 1");
	property p_pull;
		$rose(s_axi_rvalid) && s_axi_rresp == EPI_RESP_OKAY
			|-> $past(pull_ctrl) == {s_axi_rdata[4] & ~s_axi_rdata[6], s_axi_rdata[5]};
	endproperty
	a_pull: assert property (p_pull) else $error("pull mismatch");
	property p_irq;
		$rose(s_axi_rvalid) && s_axi_rresp == EPI_RESP_OKAY |-> $past(cpu_irq) == (s_axi_rdata[1] & s_axi_rdata[3]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	c_irq: cover property (cpu_irq);
	c_down: cover property (pull_ctrl == 2'h3);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == EPI_RESP_SLVERR);
	c_bstall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind epi_top epi_properties epi_properties_inst (.*);

/* dv/epi_pin_src.sv */
// signal source that drives the interrupt pin
`timescale 1ns/1ns
module epi_pin_src (
	input wire logic          mclk,
	input wire logic          drive,
	input wire logic          level,
	input epi_pkg::epi_pull_t pull,
	output logic              pin
);
	import epi_pkg::*;
	logic held_q;
	// driven pin follows level; released it follows the pull device, else the inverse of the last driven level
	always_ff @(posedge mclk) begin
		if (drive) held_q <= level;
		pin <= drive ? level : pull.pull_enable ? ~pull.pull_down : ~held_q;
	end
endmodule

/* dv/tb_top.sv */
// testbench for the external pin interrupt block
`timescale 1ns/1ns
module tb_top;
	import epi_pkg::*;
	logic        mclk = 1'h0, resetn = 1'h0, irq_pin, cpu_irq, lvl = 1'h0, drv = 1'h1;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	epi_pull_t   pull_ctrl;
	int          fails = 0, n_checks = 0, cyc = 0;
	always #5 mclk = ~mclk;
	epi_top epi_top_inst (.*);
	epi_pin_src epi_pin_src_inst (.mclk(mclk), .drive(drv), .level(lvl), .pull(pull_ctrl), .pin(irq_pin));
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// bus write, held until each channel is taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	// bus read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk("rdata", {24'h0, e}, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	// irq and pull outputs, sampled mid-cycle
	task automatic po(input logic [2:0] e);
		@(negedge mclk);
		chk("irq_pull", {29'h0, e}, {29'h0, cpu_irq, pull_ctrl});
	endtask
	// move the pin and let it pass the synchroniser
	task automatic pin(input logic v);
		@(posedge mclk);
		lvl <= v;
		repeat (6) @(posedge mclk);
	endtask
	task automatic t_regs;
		rd(12'h000, 8'h00, EPI_RESP_OKAY);
		po(3'h0);
		wr(12'h000, 8'hFF, EPI_RESP_OKAY);
		rd(12'h000, 8'h73, EPI_RESP_OKAY);
		po(3'h1);
		wr(12'h000, 8'h33, EPI_RESP_OKAY);
		po(3'h3);
		wr(12'h004, 8'h13, EPI_RESP_SLVERR);
		rd(12'h004, 8'h00, EPI_RESP_SLVERR);
		rd(12'h000, 8'h33, EPI_RESP_OKAY);
		$display("test regs done");
	endtask
	task automatic t_edge;
		wr(12'h000, 8'h22, EPI_RESP_OKAY);
		pin(1'h1);
		pin(1'h0);
		rd(12'h000, 8'h22, EPI_RESP_OKAY);
		wr(12'h000, 8'h30, EPI_RESP_OKAY);
		pin(1'h1);
		rd(12'h000, 8'h38, EPI_RESP_OKAY);
		po(3'h3);
		wr(12'h000, 8'h32, EPI_RESP_OKAY);
		po(3'h7);
		rd(12'h000, 8'h3A, EPI_RESP_OKAY);
		wr(12'h000, 8'h36, EPI_RESP_OKAY);
		rd(12'h000, 8'h32, EPI_RESP_OKAY);
		$display("test edge done");
	endtask
	task automatic t_level;
		wr(12'h000, 8'h10, EPI_RESP_OKAY);
		po(3'h2);
		pin(1'h0);
		rd(12'h000, 8'h18, EPI_RESP_OKAY);
		wr(12'h000, 8'h11, EPI_RESP_OKAY);
		wr(12'h000, 8'h15, EPI_RESP_OKAY);
		rd(12'h000, 8'h19, EPI_RESP_OKAY);
		pin(1'h1);
		wr(12'h000, 8'h15, EPI_RESP_OKAY);
		rd(12'h000, 8'h11, EPI_RESP_OKAY);
		$display("test level done");
	endtask
	// released pin: pullup with falling polarity, no pull, pulldown with rising level mode
	task automatic t_pull;
		wr(12'h000, 8'h10, EPI_RESP_OKAY);
		@(posedge mclk);
		drv <= 1'h0;
		repeat (6) @(posedge mclk);
		rd(12'h000, 8'h10, EPI_RESP_OKAY);
		wr(12'h000, 8'h50, EPI_RESP_OKAY);
		repeat (6) @(posedge mclk);
		rd(12'h000, 8'h58, EPI_RESP_OKAY);
		wr(12'h000, 8'h54, EPI_RESP_OKAY);
		rd(12'h000, 8'h50, EPI_RESP_OKAY);
		wr(12'h000, 8'h31, EPI_RESP_OKAY);
		repeat (6) @(posedge mclk);
		rd(12'h000, 8'h31, EPI_RESP_OKAY);
		$display("test pull done");
	endtask
	// late bready and rready; a write without byte lane 0 changes nothing
	task automatic t_stall;
		@(posedge mclk);
		s_axi_awaddr <= 12'h000;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'h2;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		repeat (2) @(posedge mclk);
		s_axi_bready <= 1'h1;
		do begin
			@(posedge mclk);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		s_axi_wstrb <= 4'h1;
		chk("bresp", {30'h0, EPI_RESP_OKAY}, {30'h0, s_axi_bresp});
		@(posedge mclk);
		s_axi_araddr <= 12'h000;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge mclk);
		end while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		repeat (2) @(posedge mclk);
		s_axi_rready <= 1'h1;
		do begin
			@(posedge mclk);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk("rdata", 32'h31, s_axi_rdata);
		$display("test stall done");
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			conclude;
		end
	end
	initial begin
		repeat (5) @(posedge mclk);
		resetn <= 1'h1;
		t_regs;
		t_edge;
		t_level;
		t_pull;
		t_stall;
		conclude;
	end
endmodule
